// ### src/modem_host_control_port.sv
// host control port: parallel and serial register access, detect interrupt
`timescale 1ns/1ns
module modem_host_control_port (
  input wire logic clock,
  input wire logic srst,
  input wire logic serial_shift_clock,
  input wire logic addr_latch_strobe,
  input wire logic chip_select_n,
  input wire logic read_n,
  input wire logic write_n,
  input wire logic modem_reset,
  input wire logic [host_port_pkg::REG_W-1:0] muxed_addr_data_bus_in,
  output logic [host_port_pkg::REG_W-1:0] muxed_addr_data_bus_out,
  output logic [host_port_pkg::REG_W-1:0] muxed_addr_data_bus_oe_n,
  input wire logic [host_port_pkg::REG_W-1:0] detect_status,
  output logic [host_port_pkg::REG_W-1:0] control_reg_zero,
  output logic [host_port_pkg::REG_W-1:0] control_reg_one,
  output logic [host_port_pkg::REG_W-1:0] tone_register,
  output logic interrupt_out,
  output logic interrupt_oe_n,
  output logic osc_crystal_sel
);
  import host_port_pkg::*;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [4:0] ctl_f;
  logic [REG_W-1:0] bus_f;
  logic [2:0] gray_f, gray_r;
  logic mrst_f, ale_f, cs_f, rd_f, wr_f;

  pin_filter3 #(.WIDTH(5), .RST_VAL(CTRL_PINS_RST)) u_ctl_sync (
    .clock(clock),
    .srst(srst),
    .async_in({modem_reset, addr_latch_strobe, chip_select_n, read_n, write_n}),
    .filt_out(ctl_f)
  );
  pin_filter3 #(.WIDTH(REG_W), .RST_VAL(BUS_PINS_RST)) u_bus_sync (
    .clock(clock),
    .srst(srst),
    .async_in(muxed_addr_data_bus_in),
    .filt_out(bus_f)
  );
  // bit index from the shift-clock side, gray coded so one bit moves per step
  pin_filter3 #(.WIDTH(3), .RST_VAL(GRAY_RST)) u_gray_sync (
    .clock(clock),
    .srst(srst),
    .async_in(gray_r),
    .filt_out(gray_f)
  );
  assign {mrst_f, ale_f, cs_f, rd_f, wr_f} = ctl_f;

  // ----------------------------------------------------------------
  // shift-clock domain
  // ----------------------------------------------------------------
  logic lrst_m_r, lrst_r;
  logic [REG_W-1:0] ser_word_r, ser_word_nxt;
  logic [2:0] gray_nxt;
  logic [2:0] gray_bin;

  always_comb
  begin
    gray_bin = {gray_r[2], gray_r[2] ^ gray_r[1], gray_r[2] ^ gray_r[1] ^ gray_r[0]};
    gray_nxt = gray_r;
    ser_word_nxt = ser_word_r;
    if (lrst_r)
    begin
      gray_nxt = GRAY_RST;
      ser_word_nxt = '0;
    end
    else if (!read_n)
    begin
      gray_bin = gray_bin + 3'h1;
      gray_nxt = gray_bin ^ (gray_bin >> 1);
    end
    else
      ser_word_nxt = {muxed_addr_data_bus_in[SER_DATA_BIT], ser_word_r[REG_W-1:1]};
  end

  // the shift clock may stop between frames; reset reaches it as a level
  always_ff @(negedge serial_shift_clock)
  begin
    lrst_m_r <= srst | mrst_f;
    lrst_r <= lrst_m_r;
    gray_r <= gray_nxt;
    ser_word_r <= ser_word_nxt;
  end

  // ----------------------------------------------------------------
  // register file and bus control
  // ----------------------------------------------------------------
  logic ale_prev_r, rd_prev_r, wr_prev_r;
  logic [2:0] addr_r, addr_nxt;
  logic cs_lat_r, cs_lat_nxt;
  logic [REG_W-1:0] wr_data_r, wr_data_nxt;
  logic [REG_W-1:0] cr0_r, cr0_nxt, cr1_r, cr1_nxt, tone_r, tone_nxt;
  logic [REG_W-1:0] det_prev_r;
  logic int_pend_r, int_pend_nxt, int_oe_n_r, int_oe_n_nxt;
  logic [REG_W-1:0] rd_word_r, rd_word_nxt;
  logic [2:0] base_r, base_nxt;
  logic [REG_W-1:0] out_r, out_nxt, oe_n_r, oe_n_nxt;
  logic osc_sel_r, osc_sel_nxt;
  drive_state_t drv_r, drv_nxt;
  logic ser_mode, par_sel, ale_fall, rd_fall, wr_rise, det_clr, det_set, do_wr;
  logic [2:0] serial_reg_select, wr_addr, bit_idx, idx_bin;
  logic [REG_W-1:0] par_rdata, wr_val;

  function automatic logic [REG_W-1:0] reg_read(input logic [2:0] a, input logic [REG_W-1:0] c0,
      input logic [REG_W-1:0] c1, input logic [REG_W-1:0] dt, input logic [REG_W-1:0] tn);
    case (a)
      ADDR_CTRL0: reg_read = c0;
      ADDR_CTRL1: reg_read = c1;
      ADDR_DETECT: reg_read = dt;
      ADDR_TONE: reg_read = tn;
      default: reg_read = UNMAPPED_RD;
    endcase
  endfunction

  always_comb
  begin
    ser_mode = ale_f & ~cs_f;
    serial_reg_select = bus_f[2:0];
    par_sel = ~ser_mode & ~cs_lat_r;
    ale_fall = ale_prev_r & ~ale_f;
    rd_fall = rd_prev_r & ~rd_f;
    wr_rise = ~wr_prev_r & wr_f;
    idx_bin = {gray_f[2], gray_f[2] ^ gray_f[1], gray_f[2] ^ gray_f[1] ^ gray_f[0]};
    bit_idx = idx_bin - base_r;
    par_rdata = reg_read(addr_r, cr0_r, cr1_r, detect_status, tone_r);
    addr_nxt = (ale_fall && !ser_mode) ? bus_f[2:0] : addr_r;
    cs_lat_nxt = (ale_fall && !ser_mode) ? cs_f : cs_lat_r;
    // last bus value seen while write is low is what the rising edge stores
    wr_data_nxt = (!wr_f && par_sel) ? bus_f : wr_data_r;
    do_wr = wr_rise & (ser_mode | par_sel) & ~mrst_f;
    wr_addr = ser_mode ? serial_reg_select : addr_r;
    wr_val = ser_mode ? ser_word_r : wr_data_r;
    cr0_nxt = cr0_r;
    cr1_nxt = cr1_r;
    tone_nxt = tone_r;
    if (mrst_f)
    begin
      cr0_nxt = CTRL0_RST;
      cr1_nxt = CTRL1_RST;
      tone_nxt = TONE_RST;
    end
    else if (do_wr)
    begin
      case (wr_addr)
        ADDR_CTRL0: cr0_nxt = wr_val;
        ADDR_CTRL1: cr1_nxt = wr_val;
        ADDR_TONE: tone_nxt = wr_val;
        default: cr0_nxt = cr0_r;
      endcase
    end
    osc_sel_nxt = mrst_f | ~cr1_r[CTRL1_CLK_CTRL_BIT];
    det_set = |(detect_status & ~det_prev_r) & cr1_r[CTRL1_DET_IRQ_EN_BIT];
    det_clr = rd_fall & ((ser_mode & (serial_reg_select == ADDR_DETECT))
      | (par_sel & (addr_r == ADDR_DETECT)));
    int_pend_nxt = ~mrst_f & (det_set | (int_pend_r & ~det_clr));
    int_oe_n_nxt = ~int_pend_nxt;
    // serial read word frozen once read falls, index counted from that point
    rd_word_nxt = rd_f ? reg_read(serial_reg_select, cr0_r, cr1_r, detect_status, tone_r)
      : rd_word_r;
    base_nxt = rd_fall ? idx_bin : base_r;
    drv_nxt = DRV_IDLE;
    if (!mrst_f && !rd_f)
    begin
      if (par_sel)
        drv_nxt = DRV_PAR_READ;
      else if (ser_mode)
        drv_nxt = DRV_SER_READ;
    end
    out_nxt = '0;
    oe_n_nxt = '1;
    case (drv_nxt)
      DRV_PAR_READ:
      begin
        out_nxt = par_rdata;
        oe_n_nxt = '0;
      end
      DRV_SER_READ:
      begin
        out_nxt[SER_DATA_BIT] = (drv_r == DRV_SER_READ) ? rd_word_r[bit_idx] : rd_word_r[0];
        oe_n_nxt[SER_DATA_BIT] = 1'b0;
      end
      default: oe_n_nxt = '1;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      ale_prev_r <= 1'b0;
      rd_prev_r <= 1'b1;
      wr_prev_r <= 1'b1;
      addr_r <= ADDR_CTRL0;
      cs_lat_r <= 1'b1;
      wr_data_r <= '0;
      cr0_r <= CTRL0_RST;
      cr1_r <= CTRL1_RST;
      tone_r <= TONE_RST;
      det_prev_r <= '0;
      int_pend_r <= 1'b0;
      int_oe_n_r <= 1'b1;
      rd_word_r <= '0;
      base_r <= GRAY_RST;
      out_r <= '0;
      oe_n_r <= '1;
      osc_sel_r <= 1'b1;
      drv_r <= DRV_IDLE;
    end
    else
    begin
      ale_prev_r <= ale_f;
      rd_prev_r <= rd_f;
      wr_prev_r <= wr_f;
      addr_r <= addr_nxt;
      cs_lat_r <= cs_lat_nxt;
      wr_data_r <= wr_data_nxt;
      cr0_r <= cr0_nxt;
      cr1_r <= cr1_nxt;
      tone_r <= tone_nxt;
      det_prev_r <= detect_status;
      int_pend_r <= int_pend_nxt;
      int_oe_n_r <= int_oe_n_nxt;
      rd_word_r <= rd_word_nxt;
      base_r <= base_nxt;
      out_r <= out_nxt;
      oe_n_r <= oe_n_nxt;
      osc_sel_r <= osc_sel_nxt;
      drv_r <= drv_nxt;
    end
  end

  assign muxed_addr_data_bus_out = out_r;
  assign muxed_addr_data_bus_oe_n = oe_n_r;
  assign control_reg_zero = cr0_r;
  assign control_reg_one = cr1_r;
  assign tone_register = tone_r;
  assign interrupt_out = 1'b0;
  assign interrupt_oe_n = int_oe_n_r;
  assign osc_crystal_sel = osc_sel_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_par_read_req;
    !ser_mode && !cs_lat_r && !rd_f && !mrst_f;
  endsequence
  sequence s_ale_fall;
    ale_fall && !ser_mode;
  endsequence

  AST_ALE_LATCH: assert property (@(posedge clock) disable iff (srst)
    s_ale_fall |=> addr_r == $past(bus_f[2:0]) && cs_lat_r == $past(cs_f))
    else $error("address or select not latched at strobe fall");
  AST_NO_DRIVE_UNSEL: assert property (@(posedge clock) disable iff (srst)
    (!ser_mode && cs_lat_r) |=> oe_n_r == 8'hFF)
    else $error("bus driven with latched select inactive");
  AST_PAR_READ: assert property (@(posedge clock) disable iff (srst)
    s_par_read_req |=> oe_n_r == 8'h00 && out_r == $past(par_rdata))
    else $error("parallel read data not driven");
  AST_RELEASE: assert property (@(posedge clock) disable iff (srst)
    rd_f |=> oe_n_r == 8'hFF)
    else $error("bus still driven with read high");
  AST_PAR_WRITE: assert property (@(posedge clock) disable iff (srst)
    (wr_rise && par_sel && !mrst_f && addr_r == ADDR_TONE) |=> tone_r == $past(wr_data_r))
    else $error("parallel write not stored");
  AST_SER_WRITE: assert property (@(posedge clock) disable iff (srst)
    (wr_rise && ser_mode && !mrst_f && serial_reg_select == ADDR_CTRL0)
      |=> cr0_r == $past(ser_word_r))
    else $error("serial write not stored");
  AST_INT_HOLD: assert property (@(posedge clock) disable iff (srst)
    (int_pend_r && !det_clr && !mrst_f) |=> !interrupt_oe_n)
    else $error("interrupt released without detect read");
  AST_RESET_CLEAR: assert property (@(posedge clock) disable iff (srst)
    mrst_f ##1 mrst_f |=> cr0_r == 8'h00 && cr1_r == 8'h00 && tone_r == 8'h00
      && oe_n_r == 8'hFF && interrupt_oe_n)
    else $error("registers not cleared under reset");
  AST_OSC_RESET: assert property (@(posedge clock) disable iff (srst)
    mrst_f |=> osc_crystal_sel)
    else $error("oscillator output not on crystal in reset");
  AST_SER_FIRST_BIT: assert property (@(posedge clock) disable iff (srst)
    (ser_mode && rd_fall && !mrst_f) |=> oe_n_r[SER_DATA_BIT] == 1'b0
      && out_r[SER_DATA_BIT] == $past(rd_word_r[0]))
    else $error("serial read did not present bit zero");
endmodule // modem_host_control_port

// ### src/host_port_pkg.sv
// constants for the modem host control port
package host_port_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [2:0] ADDR_CTRL0 = 3'h0;
  localparam logic [2:0] ADDR_CTRL1 = 3'h1;
  localparam logic [2:0] ADDR_DETECT = 3'h2;
  localparam logic [2:0] ADDR_TONE = 3'h3;
  localparam int REG_W = 8;
  localparam int ADDR_W = 3;
  localparam logic [7:0] CTRL0_RST = 8'h00;
  localparam logic [7:0] CTRL1_RST = 8'h00;
  localparam logic [7:0] TONE_RST = 8'h00;
  localparam logic [7:0] UNMAPPED_RD = 8'h00;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTRL1_DET_IRQ_EN_BIT = 5;
  localparam int CTRL1_CLK_CTRL_BIT = 3;
  localparam int SER_DATA_BIT = 7;
  // ----------------------------------------------------------------
  // pin reset levels and serial framing
  // ----------------------------------------------------------------
  // order: {modem_reset, addr_latch_strobe, chip_select_n, read_n, write_n}
  localparam logic [4:0] CTRL_PINS_RST = 5'h07;
  localparam logic [7:0] BUS_PINS_RST = 8'h00;
  localparam logic [2:0] GRAY_RST = 3'h0;
  localparam int SER_BITS = 8;
  // ----------------------------------------------------------------
  // bus drive state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    DRV_IDLE = 2'b00,
    DRV_PAR_READ = 2'b01,
    DRV_SER_READ = 2'b10
  } drive_state_t;
endpackage

// ### src/pin_filter3.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
module pin_filter3 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] filt_out
);
  logic [WIDTH-1:0] s1_r;
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;
  logic [WIDTH-1:0] filt_r;
  logic [WIDTH-1:0] filt_nxt;

  // a change is taken only when the second and third stages agree
  always_comb
  begin
    filt_nxt = filt_r;
    for (int i = 0; i < WIDTH; i++)
    begin
      if (s2_r[i] == s3_r[i])
        filt_nxt[i] = s3_r[i];
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      s1_r <= RST_VAL;
      s2_r <= RST_VAL;
      s3_r <= RST_VAL;
      filt_r <= RST_VAL;
    end
    else
    begin
      s1_r <= async_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      filt_r <= filt_nxt;
    end
  end

  assign filt_out = filt_r;
endmodule // pin_filter3

// ### dv/host_cpu_model.sv
// control microprocessor model driving the host port pins
`timescale 1ns/1ns
module host_cpu_model (
  input wire logic clock,
  input wire logic [7:0] bus_out,
  input wire logic [7:0] bus_oe_n,
  output logic serial_shift_clock,
  output logic addr_latch_strobe,
  output logic chip_select_n,
  output logic read_n,
  output logic write_n,
  output logic [7:0] bus_in
);
  logic [7:0] hd = 8'h00;
  logic [7:0] hen = 8'h00;
  logic [7:0] last = 8'h00;
  logic [7:0] seen_oe = 8'hFF;
  initial
  begin
    serial_shift_clock = 1'b1;
    addr_latch_strobe = 1'b0;
    chip_select_n = 1'b1;
    read_n = 1'b1;
    write_n = 1'b1;
  end
  // --------------------------------------------------------------
  // bus wire
  // --------------------------------------------------------------
  // released lines flip every cycle so a stale value cannot pass for data
  always_comb
    for (int i = 0; i < 8; i++)
      bus_in[i] = !bus_oe_n[i] ? bus_out[i] : (hen[i] ? hd[i] : ~last[i]);
  always @(posedge clock)
    last <= bus_in;
  task automatic wait_clk(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic pulse;
    #16 serial_shift_clock = 1'b0;
    #16 serial_shift_clock = 1'b1;
  endtask
  // three edges: two carry the reset level across, the third applies it
  task automatic warm;
    pulse();
    pulse();
    pulse();
    wait_clk(2);
  endtask
  // parallel cycle: address phase, then one strobe
  task automatic par_acc(input logic wr, input logic [2:0] a, input logic cs_n,
      input logic [7:0] d, output logic [7:0] q, output logic [7:0] rel);
    addr_latch_strobe = 1'b1;
    chip_select_n = cs_n;
    hd = {5'h00, a};
    hen = 8'hFF;
    wait_clk(8);
    addr_latch_strobe = 1'b0;
    wait_clk(8);
    hd = d;
    hen = wr ? 8'hFF : 8'h00;
    read_n = wr;
    write_n = !wr;
    wait_clk(12);
    q = bus_in;
    seen_oe = bus_oe_n;
    read_n = 1'b1;
    write_n = 1'b1;
    wait_clk(2);
    hen = 8'h00;
    wait_clk(10);
    rel = bus_oe_n;
  endtask
  task automatic ser_acc(input logic wr, input logic [2:0] a, input logic [7:0] d,
      output logic [7:0] q);
    q = 8'h00;
    addr_latch_strobe = 1'b1;
    chip_select_n = 1'b0;
    hd = {1'b0, 4'h0, a};
    hen = wr ? 8'hFF : 8'h7F;
    wait_clk(8);
    if (wr)
    begin
      for (int i = 0; i < 8; i++)
      begin
        hd[7] = d[i];
        pulse();
      end
      wait_clk(8);
      write_n = 1'b0;
      wait_clk(8);
      write_n = 1'b1;
    end
    else
    begin
      read_n = 1'b0;
      wait_clk(8);
      q[0] = bus_in[7];
      // bit appears some 40 to 50 ns after the fall, so look late in the cycle
      for (int i = 1; i < 8; i++)
      begin
        pulse();
        #70 q[i] = bus_in[7];
      end
      // eighth falling edge completes the frame before read is raised
      pulse();
      read_n = 1'b1;
    end
    wait_clk(10);
    hen = 8'h00;
  endtask
endmodule // host_cpu_model

// ### dv/test_modem_host_control_port.sv
// self-checking bench for the modem host control port
`timescale 1ns/1ns
module test_modem_host_control_port;
  import host_port_pkg::*;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic modem_reset = 1'b1;
  logic [7:0] detect_status = 8'h00;
  logic sck, ale, cs_n, rd_n, wr_n, int_out, int_oe_n, osc;
  logic [7:0] bus_in, bus_out, bus_oe_n, c0, c1, tn, q, rel, d;
  logic [7:0] shadow [0:3];
  logic [2:0] a;
  int n_errors = 0;
  int num_checks = 0;
  int cycles = 0;
  initial
    forever #5 clock = ~clock;
  host_cpu_model u_host (.clock(clock), .bus_out(bus_out), .bus_oe_n(bus_oe_n),
    .serial_shift_clock(sck), .addr_latch_strobe(ale), .chip_select_n(cs_n),
    .read_n(rd_n), .write_n(wr_n), .bus_in(bus_in));
  modem_host_control_port u_dut (.clock(clock), .srst(srst), .serial_shift_clock(sck),
    .addr_latch_strobe(ale), .chip_select_n(cs_n), .read_n(rd_n), .write_n(wr_n),
    .modem_reset(modem_reset), .muxed_addr_data_bus_in(bus_in),
    .muxed_addr_data_bus_out(bus_out), .muxed_addr_data_bus_oe_n(bus_oe_n),
    .detect_status(detect_status), .control_reg_zero(c0), .control_reg_one(c1),
    .tone_register(tn), .interrupt_out(int_out), .interrupt_oe_n(int_oe_n),
    .osc_crystal_sel(osc));
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  function automatic logic [7:0] exp_rd(input logic [2:0] ad);
    if (ad[2])
      return UNMAPPED_RD;
    return (ad == ADDR_DETECT) ? detect_status : shadow[ad[1:0]];
  endfunction
  task automatic check_regs;
    check("ctrl0", c0, shadow[0]);
    check("ctrl1", c1, shadow[1]);
    check("tone", tn, shadow[3]);
    check("osc", {7'h00, osc}, {7'h00, ~shadow[1][CTRL1_CLK_CTRL_BIT]});
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // --------------------------------------------------------------
  // hang guard
  // --------------------------------------------------------------
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      n_errors++;
      results();
    end
  end
  initial
  begin
    d = 8'($urandom(27));
    shadow = '{CTRL0_RST, CTRL1_RST, 8'h00, TONE_RST};
    repeat (2) @(negedge clock);
    srst = 1'b0;
    repeat (6) @(negedge clock);
    check_regs();
    check("int_rst", {7'h00, int_oe_n}, 8'h01);
    // shift-clock side clears only on its own edges while device reset is seen
    u_host.warm();
    modem_reset = 1'b0;
    repeat (6) @(negedge clock);
    u_host.warm();
    $display("test reset done");
    // --------------------------------------------------------------
    // parallel: every address once, then random
    // --------------------------------------------------------------
    detect_status = 8'h5A;
    for (int i = 0; i < 14; i++)
    begin
      a = (i < 8) ? 3'(i) : 3'($urandom);
      d = 8'($urandom) & 8'hDF;
      u_host.par_acc(1'b1, a, 1'b0, d, q, rel);
      if (!a[2] && a != ADDR_DETECT)
        shadow[a[1:0]] = d;
      u_host.par_acc(1'b0, a, 1'b0, 8'h00, q, rel);
      check("par_rd", q, exp_rd(a));
      check("par_rel", rel, 8'hFF);
      check_regs();
    end
    $display("test parallel done");
    // latched select inactive: no write, no drive
    u_host.par_acc(1'b1, ADDR_CTRL0, 1'b1, ~shadow[0], q, rel);
    check_regs();
    u_host.par_acc(1'b0, ADDR_TONE, 1'b1, 8'h00, q, rel);
    check("cs_oe", u_host.seen_oe, 8'hFF);
    $display("test select done");
    // --------------------------------------------------------------
    // serial frames
    // --------------------------------------------------------------
    for (int i = 0; i < 6; i++)
    begin
      a = (i % 3 == 2) ? ADDR_TONE : 3'(i % 3);
      d = (i == 0) ? 8'h01 : (8'($urandom) & 8'hDF);
      u_host.ser_acc(1'b1, a, d, q);
      shadow[a[1:0]] = d;
      check_regs();
      u_host.ser_acc(1'b0, a, 8'h00, q);
      check("ser_rd", q, d);
    end
    u_host.ser_acc(1'b1, ADDR_DETECT, 8'hFF, q);
    u_host.ser_acc(1'b0, ADDR_DETECT, 8'h00, q);
    check("ser_det", q, detect_status);
    check("ser_rel", bus_oe_n, 8'hFF);
    $display("test serial done");
    // --------------------------------------------------------------
    // detect interrupt
    // --------------------------------------------------------------
    detect_status = 8'h00;
    u_host.par_acc(1'b1, ADDR_CTRL1, 1'b0, 8'h20, q, rel);
    shadow[1] = 8'h20;
    detect_status = 8'h08;
    repeat (3) @(negedge clock);
    check("int_set", {7'h00, int_oe_n}, 8'h00);
    check("int_val", {7'h00, int_out}, 8'h00);
    repeat (30) @(negedge clock);
    check("int_hold", {7'h00, int_oe_n}, 8'h00);
    u_host.par_acc(1'b0, ADDR_DETECT, 1'b0, 8'h00, q, rel);
    check("det_rd", q, 8'h08);
    check("int_clr", {7'h00, int_oe_n}, 8'h01);
    $display("test interrupt done");
    // --------------------------------------------------------------
    // device reset with interrupt pending
    // --------------------------------------------------------------
    u_host.par_acc(1'b1, ADDR_TONE, 1'b0, 8'hA5, q, rel);
    detect_status = 8'h0C;
    repeat (3) @(negedge clock);
    modem_reset = 1'b1;
    repeat (8) @(negedge clock);
    shadow = '{CTRL0_RST, CTRL1_RST, 8'h00, TONE_RST};
    check_regs();
    check("int_mrst", {7'h00, int_oe_n}, 8'h01);
    modem_reset = 1'b0;
    repeat (8) @(negedge clock);
    u_host.par_acc(1'b0, ADDR_CTRL1, 1'b0, 8'h00, q, rel);
    check("rst_rd", q, CTRL1_RST);
    $display("test modem reset done");
    results();
  end
endmodule // test_modem_host_control_port
